// ---- src/abw_pkg.sv ----
package abw_pkg;

   // Bus clock made from the reference clock by a phase accumulator
   localparam int         REF_CLK_MHZ = 50;
   localparam int         BUS_CLK_MHZ = 8;
   localparam int         ACC_W       = 6;
   localparam logic [5:0] ACC_STEP    = 6'(2 * BUS_CLK_MHZ);
   localparam logic [5:0] ACC_MOD     = 6'(REF_CLK_MHZ);

   // Command wait states, counted in bus clock periods
   localparam logic [2:0] WS_16       = 3'h1;
   localparam logic [2:0] WS_8        = 3'h4;

   localparam logic [1:0] BE_LOW      = 2'h1;
   localparam logic [1:0] BE_WORD     = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ALE  = 5'h02,
      ST_CMD  = 5'h04,
      ST_END  = 5'h08,
      ST_RDY  = 5'h10
   } abw_state_t;

   typedef struct packed {
      logic        valid;
      logic        mem;
      logic        wr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } abw_req_t;

   typedef struct packed {
      logic iocs16_n;
      logic memcs16_n;
      logic iochrdy;
      logic zws_n;
   } abw_resp_t;

   typedef struct packed {
      logic ior_n;
      logic iow_n;
      logic memr_n;
      logic memw_n;
   } abw_cmd_t;

   typedef struct packed {
      logic local_en_n;
      logic local_dir;
      logic sys_en_n;
      logic sys_dir;
      logic periph_en_n;
      logic byte_lane_swap_enable;
   } abw_buf_t;

   typedef struct packed {
      abw_state_t  st;
      logic [5:0]  acc;
      logic        bus_clk;
      logic        half;
      logic        pend;
      logic        wide;
      logic        swap;
      logic [2:0]  ws_cnt;
      logic        mem;
      logic        wr;
      logic [1:0]  be;
      logic [15:0] wdata;
      logic [15:0] drive;
      logic [15:0] rdata;
      logic        sa0;
      logic        sbhe_n;
   } abw_regs_t;

endpackage : abw_pkg

// ---- src/abw_sync.sv ----
`timescale 1ns/1ns
module abw_sync #(
   parameter int W = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else if (clk_en) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : abw_sync

// ---- src/abw_bus_ctl.sv ----
// What this block does
// - Drive all local, system, peripheral buffer controls
// - Swap bytes for high-byte accesses to 8-bit targets
// - Width comes from the two 16-bit select responses
// - No select: split word into two byte accesses
// - 16-bit commands last one wait state
// - 8-bit commands last four wait states
// - Count wait states in bus clock periods
// - Sample select responses when command goes active
// - End command on zero-wait or channel ready
// - Begin with address latch, end with ready
// - Make 8 MHz bus clock, synchronise responses
`timescale 1ns/1ns
module abw_bus_ctl (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire abw_pkg::abw_req_t  cpu_req,
   output logic                   cpu_req_ready,
   output logic                   cpu_ready_out,
   output logic [15:0]            cpu_rdata,
   input  wire abw_pkg::abw_resp_t bus_resp,
   output abw_pkg::abw_cmd_t      bus_cmd,
   output abw_pkg::abw_buf_t      bus_buf,
   output logic                   expansion_bus_clock,
   output logic                   ale,
   output logic                   sa0,
   output logic                   sbhe_n,
   output logic [15:0]            sd_out,
   output logic                   sd_oe_n,
   input  wire logic [15:0]       sd_in
);
   abw_pkg::abw_regs_t  r_q;
   abw_pkg::abw_regs_t  r_d;
   abw_pkg::abw_resp_t  resp_s;
   logic [6:0]          acc_sum;
   logic                tick;
   logic                cmd_on;
   logic                cmd_end;
   logic                wide_now;
   logic [1:0]          be_eff;

   // Responses cross from the bus side into our clock
   abw_sync #(.W($bits(abw_pkg::abw_resp_t))) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .d       (bus_resp),
      .q       (resp_s)
   );

   assign acc_sum  = {1'b0, r_q.acc} + {1'b0, abw_pkg::ACC_STEP};
   // Rising edge of the bus clock; 50/8 is not whole, so spacing is 6 or 7
   assign tick     = (acc_sum >= {1'b0, abw_pkg::ACC_MOD}) && !r_q.bus_clk;
   assign cmd_on   = (r_q.st == abw_pkg::ST_CMD);
   assign wide_now = !(resp_s.iocs16_n && resp_s.memcs16_n);
   assign cmd_end  = cmd_on && tick &&
                     (!resp_s.zws_n || (r_q.ws_cnt == 3'h0 && resp_s.iochrdy));
   assign be_eff   = (cpu_req.be == 2'h0) ? abw_pkg::BE_LOW : cpu_req.be;

   always_comb begin
      r_d = r_q;
      if (acc_sum >= {1'b0, abw_pkg::ACC_MOD}) begin
         r_d.acc     = 6'(acc_sum - {1'b0, abw_pkg::ACC_MOD});
         r_d.bus_clk = !r_q.bus_clk;
      end else begin
         r_d.acc = acc_sum[5:0];
      end
      case (r_q.st)
         abw_pkg::ST_IDLE: begin
            r_d.swap = 1'b0;
            if (cpu_req.valid) begin
               r_d.mem    = cpu_req.mem;
               r_d.wr     = cpu_req.wr;
               r_d.be     = be_eff;
               r_d.wdata  = cpu_req.wdata;
               r_d.rdata  = 16'h0000;
               r_d.half   = 1'b0;
               r_d.pend   = 1'b0;
               r_d.sa0    = !be_eff[0];
               r_d.sbhe_n = !be_eff[1];
               r_d.st     = abw_pkg::ST_ALE;
            end
         end
         abw_pkg::ST_ALE: begin
            if (tick) begin
               // Width is frozen for the whole command
               r_d.wide   = wide_now;
               r_d.ws_cnt = wide_now ? abw_pkg::WS_16 : abw_pkg::WS_8;
               r_d.swap   = !wide_now && r_q.sa0;
               r_d.drive  = (!wide_now && r_q.sa0) ? {r_q.wdata[15:8], r_q.wdata[15:8]}
                                                   : r_q.wdata;
               r_d.st     = abw_pkg::ST_CMD;
            end
         end
         abw_pkg::ST_CMD: begin
            if (cmd_end) begin
               if (!r_q.wr) begin
                  if (r_q.swap) begin
                     r_d.rdata[15:8] = sd_in[7:0];
                  end else begin
                     if (!r_q.sa0) begin
                        r_d.rdata[7:0] = sd_in[7:0];
                     end
                     if (r_q.wide && !r_q.sbhe_n) begin
                        r_d.rdata[15:8] = sd_in[15:8];
                     end
                  end
               end
               if (!r_q.wide && r_q.be == abw_pkg::BE_WORD && !r_q.half) begin
                  r_d.pend = 1'b1;
                  r_d.half = 1'b1;
                  r_d.sa0  = 1'b1;
               end
               r_d.st = abw_pkg::ST_END;
            end else if (tick && r_q.ws_cnt != 3'h0) begin
               r_d.ws_cnt = r_q.ws_cnt - 3'h1;
            end
         end
         abw_pkg::ST_END: begin
            // One idle bus period between commands for recovery
            if (tick) begin
               r_d.swap = 1'b0;
               if (r_q.pend) begin
                  r_d.pend = 1'b0;
                  r_d.st   = abw_pkg::ST_ALE;
               end else begin
                  r_d.st = abw_pkg::ST_RDY;
               end
            end
         end
         abw_pkg::ST_RDY: begin
            r_d.st = abw_pkg::ST_IDLE;
         end
         default: begin
            r_d.st = abw_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q        <= '0;
         r_q.st     <= abw_pkg::ST_IDLE;
         r_q.sbhe_n <= 1'b1;
      end else if (clk_en) begin
         r_q <= r_d;
      end
   end

   assign cpu_req_ready       = (r_q.st == abw_pkg::ST_IDLE);
   assign cpu_ready_out       = (r_q.st == abw_pkg::ST_RDY);
   assign cpu_rdata           = r_q.rdata;
   assign expansion_bus_clock = r_q.bus_clk;
   assign ale                 = (r_q.st == abw_pkg::ST_ALE);
   assign sa0                 = r_q.sa0;
   assign sbhe_n              = r_q.sbhe_n;
   assign sd_out              = r_q.drive;
   assign sd_oe_n             = !(cmd_on && r_q.wr);

   assign bus_cmd.ior_n  = !(cmd_on && !r_q.mem && !r_q.wr);
   assign bus_cmd.iow_n  = !(cmd_on && !r_q.mem && r_q.wr);
   assign bus_cmd.memr_n = !(cmd_on && r_q.mem && !r_q.wr);
   assign bus_cmd.memw_n = !(cmd_on && r_q.mem && r_q.wr);

   // Local buffer spans the whole bus cycle, system buffer only the command
   assign bus_buf.local_en_n            = (r_q.st == abw_pkg::ST_IDLE);
   assign bus_buf.local_dir             = !r_q.wr;
   assign bus_buf.sys_en_n              = !cmd_on;
   assign bus_buf.sys_dir               = r_q.wr;
   assign bus_buf.periph_en_n           = !(cmd_on && !r_q.mem);
   assign bus_buf.byte_lane_swap_enable = cmd_on && r_q.swap;

   // Helper counters for the checks below
   logic [3:0] cmd_ticks_q;
   logic       rdy_lo_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ticks_q <= 4'h0;
         rdy_lo_q    <= 1'b0;
      end else if (clk_en) begin
         if (!cmd_on) begin
            cmd_ticks_q <= 4'h0;
            rdy_lo_q    <= 1'b0;
         end else if (tick) begin
            cmd_ticks_q <= cmd_ticks_q + 4'h1;
            rdy_lo_q    <= rdy_lo_q || !resp_s.iochrdy;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n || !clk_en);

   property p_buf_cover;
      !bus_cmd.ior_n || !bus_cmd.iow_n || !bus_cmd.memr_n || !bus_cmd.memw_n
         |-> !bus_buf.local_en_n && !bus_buf.sys_en_n;
   endproperty
   a_buf_cover: assert property (p_buf_cover) else $error("buffers off during command");

   property p_swap_only_narrow;
      bus_buf.byte_lane_swap_enable |-> !r_q.wide && sa0;
   endproperty
   a_swap_only_narrow: assert property (p_swap_only_narrow) else $error("bad swap");

   property p_width_from_cs;
      $rose(cmd_on) |-> r_q.wide == $past(wide_now);
   endproperty
   a_width_from_cs: assert property (p_width_from_cs) else $error("width mismatch");

   property p_split;
      cmd_end && !r_q.wide && r_q.be == abw_pkg::BE_WORD && !r_q.half
         |=> (r_q.st == abw_pkg::ST_END) ##[1:8] ale;
   endproperty
   a_split: assert property (p_split) else $error("no second byte access");

   property p_ws16;
      cmd_end && r_q.wide && resp_s.zws_n && !rdy_lo_q && resp_s.iochrdy
         |-> cmd_ticks_q == 4'(abw_pkg::WS_16);
   endproperty
   a_ws16: assert property (p_ws16) else $error("16-bit wait count wrong");

   property p_ws8;
      cmd_end && !r_q.wide && resp_s.zws_n && !rdy_lo_q && resp_s.iochrdy
         |-> cmd_ticks_q == 4'(abw_pkg::WS_8);
   endproperty
   a_ws8: assert property (p_ws8) else $error("8-bit wait count wrong");

   property p_tick_rate;
      tick |=> !tick [*5] ##[1:2] tick;
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("bus clock rate wrong");

   property p_width_stable;
      cmd_on && $past(cmd_on) |-> $stable(r_q.wide);
   endproperty
   a_width_stable: assert property (p_width_stable) else $error("width changed");

   property p_end_cmd;
      cmd_on && tick && !resp_s.zws_n |=> !cmd_on;
   endproperty
   a_end_cmd: assert property (p_end_cmd) else $error("command not ended");

   property p_ale_first;
      $rose(cmd_on) |-> $past(ale);
   endproperty
   a_ale_first: assert property (p_ale_first) else $error("command without latch");

   property p_ready_last;
      cpu_ready_out |-> !r_q.pend && (r_q.be != abw_pkg::BE_WORD || r_q.wide || r_q.half);
   endproperty
   a_ready_last: assert property (p_ready_last) else $error("ready before high byte");

   c_split:  cover property (cmd_end && r_q.half);
   c_wide:   cover property (cmd_end && r_q.wide);
   c_zws:    cover property (cmd_end && !resp_s.zws_n);
   c_ready:  cover property (cpu_ready_out && !r_q.wr);
endmodule : abw_bus_ctl

// ---- tb/abw_bus_model.sv ----
`timescale 1ns/1ns
module abw_bus_model (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire abw_pkg::abw_cmd_t bus_cmd,
   input  wire logic              sa0,
   input  wire logic              sbhe_n,
   input  wire logic [15:0]       sd_out,
   input  wire logic              sd_oe_n,
   input  wire logic              wide,
   input  wire logic              cs_sel,
   input  wire logic              zws,
   input  wire logic [7:0]        slow,
   output abw_pkg::abw_resp_t     bus_resp,
   output logic [15:0]            sd_in
);
   logic [7:0] mem_b [2];
   logic [7:0] cnt;
   logic       rd;
   logic       wr;
   assign rd = !bus_cmd.ior_n || !bus_cmd.memr_n;
   assign wr = !bus_cmd.iow_n || !bus_cmd.memw_n;
   assign bus_resp.iocs16_n  = !(wide && !cs_sel);
   assign bus_resp.memcs16_n = !(wide && cs_sel);
   assign bus_resp.iochrdy   = !((rd || wr) && cnt < slow);
   assign bus_resp.zws_n     = !((rd || wr) && zws);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt      <= 8'h00;
         sd_in    <= 16'h5a5a;
         mem_b[0] <= 8'h00;
         mem_b[1] <= 8'h00;
      end else begin
         cnt <= (rd || wr) ? cnt + 8'(cnt != 8'hff) : 8'h00;
         if (wr && !sd_oe_n && !wide) mem_b[sa0] <= sd_out[7:0];
         if (wr && !sd_oe_n && wide && !sa0) mem_b[0] <= sd_out[7:0];
         if (wr && !sd_oe_n && wide && !sbhe_n) mem_b[1] <= sd_out[15:8];
         // Released lanes toggle so stale data cannot pass for a read
         if (!rd) sd_in <= ~sd_in;
         else if (wide) sd_in <= {mem_b[1], mem_b[0]};
         else sd_in <= {~mem_b[sa0], mem_b[sa0]};
      end
   end
endmodule : abw_bus_model

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
   logic               ref_clk = 1'b0;
   logic               rst_n = 1'b0;
   abw_pkg::abw_req_t  cpu_req = '0;
   abw_pkg::abw_resp_t bus_resp;
   abw_pkg::abw_cmd_t  bus_cmd;
   abw_pkg::abw_buf_t  bus_buf;
   logic               cpu_req_ready;
   logic               cpu_ready_out;
   logic [15:0]        cpu_rdata;
   logic               ale;
   logic               sa0;
   logic               sbhe_n;
   logic [15:0]        sd_out;
   logic               sd_oe_n;
   logic [15:0]        sd_in;
   logic               wide = 1'b0;
   logic               cs_sel = 1'b0;
   logic               zws = 1'b0;
   logic [7:0]         slow = 8'h00;
   logic               cur_wr = 1'b0;
   logic               cur_mem = 1'b0;
   logic               ale_seen = 1'b0;
   logic [15:0]        shadow = 16'h0000;
   logic [7:0]         cmd_len = 8'h00;
   logic [7:0]         rec_len [$];
   logic [2:0]         rec_pos [$];
   logic [31:0]        seed = 32'h0001_7f0b;
   logic [31:0]        r;
   int                 error_cnt = 0;
   int                 check_count = 0;
   logic               clk_en = 1'b1;
   logic               bclk;
   logic               bclk_was = 1'b0;
   logic               bclk_hold = 1'b0;
   logic [3:0]         bclk_gap = 4'h0;

   always #10 ref_clk = ~ref_clk;

   abw_bus_ctl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cpu_req(cpu_req),
      .cpu_req_ready(cpu_req_ready), .cpu_ready_out(cpu_ready_out), .cpu_rdata(cpu_rdata),
      .bus_resp(bus_resp), .bus_cmd(bus_cmd), .bus_buf(bus_buf), .expansion_bus_clock(bclk),
      .ale(ale), .sa0(sa0), .sbhe_n(sbhe_n), .sd_out(sd_out), .sd_oe_n(sd_oe_n), .sd_in(sd_in));
   abw_bus_model i_bus (.ref_clk(ref_clk), .rst_n(rst_n), .bus_cmd(bus_cmd), .sa0(sa0),
      .sbhe_n(sbhe_n), .sd_out(sd_out), .sd_oe_n(sd_oe_n), .wide(wide), .cs_sel(cs_sel),
      .zws(zws), .slow(slow), .bus_resp(bus_resp), .sd_in(sd_in));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Command length in reference cycles; a bus period is 6 or 7 of them
   function automatic logic len_ok(input logic [7:0] n, input logic wi, zw, input logic [7:0] sl);
      if (zw) return n >= 8'h03 && n <= 8'h08;
      if (sl != 8'h00) return n >= sl && n <= sl + 8'h0e;
      return wi ? (n >= 8'h0c && n <= 8'h0e) : (n >= 8'h1e && n <= 8'h22);
   endfunction : len_ok

   // Expected {high enable, address bit 0, lane swap} of one byte access
   function automatic logic [2:0] exp_pos(input logic hi, input logic [1:0] be, input logic wi);
      return {be == 2'h1, hi || be == 2'h2, hi || (be == 2'h2 && !wi)};
   endfunction : exp_pos

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   always @(posedge ref_clk) begin
      if (!(&bus_cmd)) begin
         if (cmd_len == 8'h00) begin
            if (rec_pos.size() == 0) chk(16'(ale_seen), 16'h0001);
            rec_pos.push_back({sbhe_n, sa0, bus_buf.byte_lane_swap_enable});
            chk(16'({bus_buf.local_en_n, bus_buf.local_dir, bus_buf.sys_en_n, bus_buf.sys_dir,
               bus_buf.periph_en_n, sd_oe_n}),
               16'({1'b0, !cur_wr, 1'b0, cur_wr, cur_mem, !cur_wr}));
         end
         cmd_len = cmd_len + 8'h01;
      end else if (cmd_len != 8'h00) begin
         rec_len.push_back(cmd_len);
         cmd_len = 8'h00;
      end
      if (ale === 1'b1) ale_seen = 1'b1;
      // Bus clock rises every 6 or 7 reference cycles
      if (rst_n !== 1'b1 || clk_en !== 1'b1) begin
         bclk_gap = 4'h0;
      end else if (bclk === 1'b1 && !bclk_was) begin
         if (bclk_gap != 4'h0) chk(16'(bclk_gap >= 4'h6 && bclk_gap <= 4'h7), 16'h0001);
         bclk_gap = 4'h1;
      end else if (bclk_gap != 4'h0 && bclk_gap != 4'hf) begin
         bclk_gap = bclk_gap + 4'h1;
      end
      bclk_was = bclk;
   end

   task automatic op(input logic m, w, input logic [1:0] be, input logic [15:0] wd,
                     input logic wi, cs, zw, input logic [7:0] sl);
      int          n;
      logic [15:0] mask;
      wide    <= wi;
      cs_sel  <= cs;
      zws     <= zw;
      slow    <= sl;
      cur_mem = m;
      cur_wr  = w;
      ale_seen = 1'b0;
      rec_len.delete();
      rec_pos.delete();
      // Width selects need the two-stage sync before the address phase can end
      repeat (2) @(posedge ref_clk);
      cpu_req <= '{valid: 1'b1, mem: m, wr: w, be: be, wdata: wd};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (cpu_req_ready !== 1'b1 && n < 20);
      chk(16'(n < 20), 16'h0001);
      cpu_req.valid <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (cpu_ready_out !== 1'b1 && n < 600);
      chk(16'(n < 600), 16'h0001);
      mask = (be == 2'h3) ? 16'hffff : (be == 2'h2) ? 16'hff00 : 16'h00ff;
      if (!w) chk(cpu_rdata & mask, shadow & mask);
      else shadow = (shadow & ~mask) | (wd & mask);
      chk(16'(rec_len.size()), (wi || be != 2'h3) ? 16'h0001 : 16'h0002);
      for (int k = 0; k < rec_len.size(); k++) begin
         chk(16'(rec_pos[k]), 16'(exp_pos(k == 1, be, wi)));
         chk(16'(len_ok(rec_len[k], wi, zw, sl)), 16'h0001);
      end
   endtask : op

   initial begin
      #1_000_000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int t = 0; t < 8; t++) begin
         r = xs();
         op(t[0], 1'b1, 2'h3, r[15:0], t[1], t[2], 1'b0, 8'h00);
         op(t[0], 1'b0, 2'h3, 16'h0000, t[1], t[2], 1'b0, 8'h00);
      end
      $display("width table done");
      for (int i = 0; i < 24; i++) begin
         r = xs();
         op(r[0], r[1], r[2] ? 2'h3 : {r[5], !r[5]}, r[31:16], r[3], r[4], 1'b0, 8'h00);
      end
      $display("random mix done");
      op(1'b0, 1'b0, 2'h3, 16'h0000, 1'b1, 1'b0, 1'b1, 8'h00);
      op(1'b1, 1'b1, 2'h1, 16'h00c3, 1'b0, 1'b0, 1'b1, 8'h00);
      op(1'b1, 1'b0, 2'h3, 16'h0000, 1'b1, 1'b1, 1'b0, 8'h28);
      op(1'b0, 1'b1, 2'h3, 16'h9e71, 1'b1, 1'b0, 1'b0, 8'h3c);
      $display("ready and zero wait done");
      // A request while frozen must not be taken, and the bus clock must stop
      clk_en <= 1'b0;
      cpu_req <= '{valid: 1'b1, mem: 1'b0, wr: 1'b0, be: 2'h3, wdata: 16'h0000};
      @(posedge ref_clk);
      bclk_hold = bclk;
      repeat (8) begin
         @(posedge ref_clk);
         chk(16'({cpu_req_ready, ale, bclk}), 16'({2'b10, bclk_hold}));
      end
      cpu_req.valid <= 1'b0;
      clk_en <= 1'b1;
      $display("clock enable freeze done");
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(16'({cpu_req_ready, bus_cmd, sbhe_n, sd_oe_n, ale, cpu_ready_out, bus_buf.local_en_n}),
          16'h03f9);
      shadow = 16'h0000;
      rst_n <= 1'b1;
      op(1'b0, 1'b0, 2'h3, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h00);
      $display("mid-run reset done");
      give_verdict();
   end
endmodule : tb
